// ===== iwc_wake.sv
// Function
// - nested preemption across four priority levels
// - two-bit priority field per source
// - thirty-two vectors, each own input, pending, priority
// - request to handler start within fifteen cycles
// - pending interrupt wakes wait and low-power wait
// - stopped clocks: detect wake, restart system clock
// - after restart, pending interrupt handled normally
// - wakes from partial stop, stop, low-power stop
// - reset pin, watchdog, clock/lock loss wake
// - enabled pin interrupts wake from stop modes
// - clocked peripherals wake only on slow/external osc
// - converter wake optional, needs slow/external osc
// - clock generator wakes only stop, slow osc
// - vector controller off in stop; wake controller wakes
// - wait instructions enter wait or stop per configuration
package iwc_pkg;
    localparam int unsigned NUM_VEC     = 32;          // vector count
    localparam int unsigned VEC_W       = 5;           // vector number width
    localparam int unsigned PRIO_W      = 2;           // priority field width
    localparam int unsigned NUM_LVL     = 4;           // priority levels, 0 highest
    localparam int unsigned LAT_MAX_CYC = 15;          // request to handler, cycles
    localparam int unsigned PIN_W       = 8;           // pin interrupt lines
    localparam int unsigned NUM_CLKD    = 6;           // wake sources needing a clock
    localparam int unsigned NUM_FREE    = 5;           // always-running wake sources
    localparam int unsigned NUM_RST     = 4;           // reset-type wake sources
    localparam int unsigned WSRC_N      = 14;          // wake cause vector width
    // wake cause bit positions
    localparam int unsigned WS_RESET    = 0;
    localparam int unsigned WS_PIN      = 1;
    localparam int unsigned WS_CLKD0    = 2;           // compare, 3 serial, periodic, converter
    localparam int unsigned WS_CONV     = 7;           // converter within the clocked group
    localparam int unsigned WS_FREE0    = 8;           // tick timer, rtc, can, touch, nmi
    localparam int unsigned WS_GEN      = 13;          // clock generator
    // peripheral clock source codes
    localparam logic [1:0]  CK_NONE     = 2'h0;
    localparam logic [1:0]  CK_SLOW     = 2'h1;        // slow_internal_osc
    localparam logic [1:0]  CK_XOSC     = 2'h2;        // external_oscillator
    localparam logic [1:0]  CK_FAST     = 2'h3;
    // sleep configuration codes
    localparam logic [1:0]  CFG_WAIT    = 2'h0;
    localparam logic [1:0]  CFG_STOP    = 2'h1;
    localparam logic [1:0]  CFG_PSTOP   = 2'h2;
    localparam logic [1:0]  PRIO_RST    = 2'h3;        // lowest level
    localparam logic [3:0]  ACT_RST     = 4'h0;        // nothing running
    localparam logic [NUM_VEC-1:0] PEND_RST = 32'h0000_0000;
    localparam logic [WSRC_N-1:0]  CAUSE_RST = 14'h0000;

    typedef enum logic [2:0] {
        IWC_RUN    = 3'b000,
        IWC_WAIT   = 3'b001,
        IWC_LPWAIT = 3'b010,
        IWC_STOP   = 3'b011,
        IWC_LPSTOP = 3'b100,
        IWC_PSTOP  = 3'b101,
        IWC_RESUME = 3'b110
    } iwc_mode_t;
endpackage

`timescale 1ns/1ns
// async_wake_controller: runs on the always-on clock, system clock may be off
module iwc_wake
    import iwc_pkg::*;
(
    input  wire logic                  i_clk,
    input  wire logic                  i_resetn,
    input  wire logic                  i_ce,
    input  wire logic                  i_stop_active,  // any stop state
    input  wire logic                  i_plain_stop,   // stop, not low-power stop
    input  wire logic [NUM_RST-1:0]    i_reset_src,    // pin, watchdog, clock loss, lock loss
    input  wire logic [PIN_W-1:0]      i_pin_int,
    input  wire logic [PIN_W-1:0]      i_pin_int_en,   // port control enables
    input  wire logic [NUM_CLKD-1:0]   i_clkd_evt,
    input  wire logic [2*NUM_CLKD-1:0] i_clkd_sel,     // clock source per clocked source
    input  wire logic                  i_conv_wake_en,
    input  wire logic [NUM_FREE-1:0]   i_free_evt,
    input  wire logic                  i_gen_evt,
    input  wire logic                  i_gen_slow,     // generator on slow internal osc
    input  wire logic [WSRC_N-1:0]     i_wake_mask,
    output logic                       o_wake,
    output logic [WSRC_N-1:0]          o_wake_cause
);
    // only the two low-power oscillators keep running in stop
    function automatic logic clk_ok(input logic [1:0] sel);
        clk_ok = (sel == CK_SLOW) || (sel == CK_XOSC);
    endfunction

    logic [WSRC_N-1:0] cause;       // qualified events this cycle
    logic              next_wake;
    logic [WSRC_N-1:0] next_cause;

    // qualify each source but the reset group against the mask, clocked ones also against their clock
    always_comb begin
        cause = CAUSE_RST;
        cause[WS_RESET] = |i_reset_src;
        cause[WS_PIN]   = |(i_pin_int & i_pin_int_en) & i_wake_mask[WS_PIN];
        for (int k = 0; k < NUM_CLKD; k++) begin
            cause[WS_CLKD0+k] = i_clkd_evt[k] & clk_ok(i_clkd_sel[2*k +: 2])
                                & i_wake_mask[WS_CLKD0+k];
        end
        // converter is opt-in on top of the mask
        cause[WS_CONV] = cause[WS_CONV] & i_conv_wake_en;
        for (int k = 0; k < NUM_FREE; k++) begin
            cause[WS_FREE0+k] = i_free_evt[k] & i_wake_mask[WS_FREE0+k];
        end
        cause[WS_GEN] = i_gen_evt & i_gen_slow & i_plain_stop & i_wake_mask[WS_GEN];
        next_wake  = i_stop_active && (|cause);
        next_cause = next_wake ? cause : o_wake_cause;
    end

    // registered request to clock control, cause kept for software
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_wake       <= 1'b0;
            o_wake_cause <= CAUSE_RST;
        end else if (i_ce) begin
            o_wake       <= next_wake;
            o_wake_cause <= next_cause;
        end
    end

    reset_wake_a: assert property (@(posedge i_clk) disable iff (!i_resetn || !i_ce)
        i_stop_active && (|i_reset_src) |=> o_wake && o_wake_cause[WS_RESET])
        else $error("reset source did not wake from stop");
    mask_gate_a: assert property (@(posedge i_clk) disable iff (!i_resetn || !i_ce)
        ~|i_reset_src && ~|i_wake_mask |=> !o_wake)
        else $error("masked sources woke the system");
    gen_stop_a: assert property (@(posedge i_clk) disable iff (!i_resetn || !i_ce)
        o_wake_cause[WS_GEN] && $changed(o_wake_cause) |-> $past(i_plain_stop && i_gen_slow))
        else $error("clock generator woke outside stop or off slow osc");
endmodule // iwc_wake

// ===== iwc_ctrl.sv
`timescale 1ns/1ns
// nested_vector_controller plus power-mode sequencing
module iwc_ctrl
    import iwc_pkg::*;
(
    input  wire logic                  i_clk,
    input  wire logic                  i_resetn,
    input  wire logic                  i_ce,
    input  wire logic [NUM_VEC-1:0]    i_irq,          // source levels
    input  wire logic [NUM_VEC-1:0]    i_irq_en,
    input  wire logic [2*NUM_VEC-1:0]  i_prio,         // priority_registers image
    input  wire logic                  i_core_ack,     // core took the vector
    input  wire logic                  i_core_exit,    // handler returned
    input  wire logic                  i_slp_irq,      // wait_for_irq_insn executed
    input  wire logic                  i_slp_evt,      // wait_for_event_insn executed
    input  wire logic                  i_event,
    input  wire logic [1:0]            i_stop_cfg,
    input  wire logic                  i_vlp,          // very-low-power configuration
    input  wire logic                  i_clk_stable,   // clock control: clocks back
    input  wire logic [NUM_RST-1:0]    i_reset_src,
    input  wire logic [PIN_W-1:0]      i_pin_int,
    input  wire logic [PIN_W-1:0]      i_pin_int_en,
    input  wire logic [NUM_CLKD-1:0]   i_clkd_evt,
    input  wire logic [2*NUM_CLKD-1:0] i_clkd_sel,
    input  wire logic                  i_conv_wake_en,
    input  wire logic [NUM_FREE-1:0]   i_free_evt,
    input  wire logic                  i_gen_evt,
    input  wire logic                  i_gen_slow,
    input  wire logic [WSRC_N-1:0]     i_wake_mask,
    output logic                       o_irq_req,
    output logic [VEC_W-1:0]           o_irq_vec,
    output logic [PRIO_W-1:0]          o_irq_prio,
    output logic                       o_core_sleep,
    output logic                       o_sys_clk_run,
    output iwc_mode_t                  o_mode,
    output logic                       o_wake,
    output logic [WSRC_N-1:0]          o_wake_cause
);
    // pick the pending source with the numerically lowest level; ties go
    // to the lowest vector, which keeps the choice stable between cycles
    function automatic logic [VEC_W+PRIO_W:0] pick_best(input logic [NUM_VEC-1:0] req,
                                                        input logic [2*NUM_VEC-1:0] prio);
        logic              found;
        logic [VEC_W-1:0]  vec;
        logic [PRIO_W-1:0] lvl;
        found = 1'b0;
        vec   = '0;
        lvl   = PRIO_RST;
        for (int i = NUM_VEC - 1; i >= 0; i--) begin
            if (req[i] && (!found || prio[2*i +: 2] <= lvl)) begin
                found = 1'b1;
                vec   = VEC_W'(i);
                lvl   = prio[2*i +: 2];
            end
        end
        pick_best = {found, vec, lvl};
    endfunction

    // highest active level, the one whose handler is running
    function automatic logic [PRIO_W-1:0] top_level(input logic [NUM_LVL-1:0] act);
        logic [PRIO_W-1:0] lvl;
        lvl = PRIO_RST;
        for (int l = NUM_LVL - 1; l >= 0; l--) begin
            if (act[l]) begin
                lvl = PRIO_W'(l);
            end
        end
        top_level = lvl;
    endfunction

    logic [NUM_VEC-1:0] pend;           // pending latches, one per vector
    logic [NUM_LVL-1:0] act;            // levels with a handler in flight
    logic               evt_sleep;      // current sleep entered by event wait
    logic [NUM_VEC-1:0] next_pend;
    logic [NUM_LVL-1:0] next_act;
    logic               next_req;
    logic [VEC_W-1:0]   next_vec;
    logic [PRIO_W-1:0]  next_prio;
    iwc_mode_t          next_mode;
    logic               next_sleep;
    logic               next_clk_run;
    logic               next_evt_sleep;
    logic               is_stop;        // any stop state
    logic               vect_on;        // vector controller clocked
    logic               best_valid;
    logic [VEC_W-1:0]   best_vec;
    logic [PRIO_W-1:0]  best_prio;
    logic [PRIO_W-1:0]  run_lvl;
    logic               eligible;       // best may preempt what runs
    logic               take;           // core accepts the request

    // wake controller owns every exit from the stop states
    iwc_wake u_wake (
        .i_clk          (i_clk),
        .i_resetn       (i_resetn),
        .i_ce           (i_ce),
        .i_stop_active  (is_stop),
        .i_plain_stop   (o_mode == IWC_STOP),
        .i_reset_src    (i_reset_src),
        .i_pin_int      (i_pin_int),
        .i_pin_int_en   (i_pin_int_en),
        .i_clkd_evt     (i_clkd_evt),
        .i_clkd_sel     (i_clkd_sel),
        .i_conv_wake_en (i_conv_wake_en),
        .i_free_evt     (i_free_evt),
        .i_gen_evt      (i_gen_evt),
        .i_gen_slow     (i_gen_slow),
        .i_wake_mask    (i_wake_mask),
        .o_wake         (o_wake),
        .o_wake_cause   (o_wake_cause)
    );

    // arbitration and pending / active bookkeeping
    always_comb begin
        is_stop  = (o_mode == IWC_STOP) || (o_mode == IWC_LPSTOP) || (o_mode == IWC_PSTOP);
        vect_on  = !is_stop;
        {best_valid, best_vec, best_prio} = pick_best(pend & i_irq_en, i_prio);
        run_lvl  = top_level(act);
        // strictly higher level needed to interrupt a running handler
        eligible = best_valid && ((act == ACT_RST) || (best_prio < run_lvl));
        take     = i_core_ack && o_irq_req;
        next_pend = pend;
        if (vect_on) begin
            for (int i = 0; i < NUM_VEC; i++) begin
                // a fresh request in the ack cycle stays pending
                next_pend[i] = (i_irq[i] & i_irq_en[i])
                               | (pend[i] & ~(take && (o_irq_vec == VEC_W'(i))));
            end
        end
        next_act = act;
        if (i_core_exit) begin
            next_act[run_lvl] = 1'b0;
        end
        if (take) begin
            next_act[o_irq_prio] = 1'b1;
        end
        // drop the request for a cycle after an ack so the taken vector,
        // not yet cleared, is never offered twice
        next_req  = vect_on && eligible && !take;
        next_vec  = next_req ? best_vec : o_irq_vec;
        next_prio = next_req ? best_prio : o_irq_prio;
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            pend       <= PEND_RST;
            act        <= ACT_RST;
            o_irq_req  <= 1'b0;
            o_irq_vec  <= '0;
            o_irq_prio <= PRIO_RST;
        end else if (i_ce) begin
            pend       <= next_pend;
            act        <= next_act;
            o_irq_req  <= next_req;
            o_irq_vec  <= next_vec;
            o_irq_prio <= next_prio;
        end
    end

    // power-mode sequencer
    always_comb begin
        next_mode = o_mode;
        next_evt_sleep = evt_sleep;
        unique case (o_mode)
            IWC_RUN: begin
                // nothing to sleep on if an interrupt is already due
                if ((i_slp_irq || i_slp_evt) && !eligible) begin
                    next_evt_sleep = i_slp_evt && !i_slp_irq;
                    unique case (i_stop_cfg)
                        CFG_STOP:  next_mode = i_vlp ? IWC_LPSTOP : IWC_STOP;
                        CFG_PSTOP: next_mode = IWC_PSTOP;
                        default:   next_mode = i_vlp ? IWC_LPWAIT : IWC_WAIT;
                    endcase
                end
            end
            IWC_WAIT, IWC_LPWAIT: begin
                // vector controller still clocked, it wakes the core
                if (eligible || (evt_sleep && i_event)) begin
                    next_mode = IWC_RUN;
                end
            end
            IWC_STOP, IWC_LPSTOP, IWC_PSTOP: begin
                if (o_wake) begin
                    next_mode = IWC_RESUME;
                end
            end
            IWC_RESUME: begin
                // clocks run again; pending latches refill from the levels
                if (i_clk_stable) begin
                    next_mode = IWC_RUN;
                end
            end
            default: begin
                next_mode = IWC_RUN;
            end
        endcase
        next_sleep   = (next_mode != IWC_RUN);
        next_clk_run = !((next_mode == IWC_STOP) || (next_mode == IWC_LPSTOP)
                         || (next_mode == IWC_PSTOP));
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_mode        <= IWC_RUN;
            evt_sleep     <= 1'b0;
            o_core_sleep  <= 1'b0;
            o_sys_clk_run <= 1'b1;
        end else if (i_ce) begin
            o_mode        <= next_mode;
            evt_sleep     <= next_evt_sleep;
            o_core_sleep  <= next_sleep;
            o_sys_clk_run <= next_clk_run;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn || !i_ce);

    preempt_level_a: assert property (o_irq_req && (act != ACT_RST) |-> o_irq_prio < run_lvl)
        else $error("request does not outrank running handler");
    ack_clears_a: assert property (take && vect_on && !(i_irq[o_irq_vec] && i_irq_en[o_irq_vec])
        |=> !pend[$past(o_irq_vec)] && !o_irq_req)
        else $error("taken vector stayed pending");
    req_latency_a: assert property (vect_on && eligible && !take |=> o_irq_req)
        else $error("eligible interrupt not requested next cycle");
    wait_wake_a: assert property (((o_mode == IWC_WAIT) || (o_mode == IWC_LPWAIT)) && eligible
        |=> o_mode == IWC_RUN && !o_core_sleep)
        else $error("wait mode did not wake on interrupt");
    stop_exit_a: assert property (is_stop && o_wake |=> o_mode == IWC_RESUME && o_sys_clk_run)
        else $error("stop mode ignored wake request");
    clock_resume_a: assert property (o_mode == IWC_RESUME && i_clk_stable |=> o_mode == IWC_RUN)
        else $error("resume did not return to run");
    stop_freeze_a: assert property (is_stop |=> $stable(pend))
        else $error("pending changed while controller off");
    sleep_entry_a: assert property (o_mode == IWC_RUN && i_slp_irq && !eligible && i_stop_cfg == CFG_STOP
        && !i_vlp |=> o_mode == IWC_STOP && !o_sys_clk_run ##1 !o_sys_clk_run || o_wake)
        else $error("stop configuration did not enter stop");
endmodule // iwc_ctrl

// ===== iwc_core_model.sv
`timescale 1ns/1ns
// core and clock-control stand-in: takes vectors late, restarts clocks late
module iwc_core_model
    import iwc_pkg::*;
#(
    parameter int unsigned SETTLE = 3     // cycles for clocks to come back
)(
    input  wire logic       i_clk,
    input  wire logic       i_resetn,
    input  wire logic [3:0] i_ack_dly,    // cycles a request stands before taken
    input  wire logic       i_irq_req,
    input  wire logic       i_sys_clk_run,
    output logic            o_core_ack,
    output logic            o_clk_stable
);
    logic [3:0] wait_cnt;                 // age of the standing request
    logic [3:0] next_wait_cnt;
    logic [3:0] run_cnt;                  // cycles since restart was asked
    logic [3:0] next_run_cnt;
    logic       next_core_ack;
    logic       next_clk_stable;
    // one-cycle take pulse, never twice in a row
    always_comb begin
        // a core whose clocks are still settling cannot take a vector
        next_core_ack = i_irq_req && !o_core_ack && (wait_cnt >= i_ack_dly) && o_clk_stable;
        next_wait_cnt = (i_irq_req && !o_core_ack) ? wait_cnt + 4'h1 : 4'h0;
        // stable drops at once when stopped, so a slow restart is exercised
        next_run_cnt = i_sys_clk_run ? run_cnt : 4'h0;
        if (i_sys_clk_run && run_cnt != SETTLE[3:0]) begin
            next_run_cnt = run_cnt + 4'h1;
        end
        next_clk_stable = i_sys_clk_run && (run_cnt == SETTLE[3:0]);
    end
    // registers only
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            wait_cnt     <= 4'h0;
            run_cnt      <= SETTLE[3:0];   // clocks already run out of reset
            o_core_ack   <= 1'b0;
            o_clk_stable <= 1'b1;
        end else begin
            wait_cnt     <= next_wait_cnt;
            run_cnt      <= next_run_cnt;
            o_core_ack   <= next_core_ack;
            o_clk_stable <= next_clk_stable;
        end
    end
endmodule // iwc_core_model

// ===== iwc_ctrl_bench.sv
`timescale 1ns/1ns
// stand-in core answers requests; tasks drive sleep and wake sources
module iwc_ctrl_bench
    import iwc_pkg::*;
;
    localparam int LIMIT = 20000;          // cycle ceiling, run needs ~650
    logic                  clk, resetn, ce; // ce held high
    logic [NUM_VEC-1:0]    irq, irq_en;
    logic [2*NUM_VEC-1:0]  prio;
    logic                  core_ack, core_exit, slp_irq, slp_evt, evt, vlp, clk_stable;
    logic [1:0]            stop_cfg;
    logic [NUM_RST-1:0]    reset_src;
    logic [PIN_W-1:0]      pin_int, pin_en;
    logic [NUM_CLKD-1:0]   clkd_evt;
    logic [2*NUM_CLKD-1:0] clkd_sel;
    logic                  conv_en, gen_evt, gen_slow, irq_req, core_sleep, sys_clk_run, wake;
    logic [NUM_FREE-1:0]   free_evt;
    logic [WSRC_N-1:0]     wake_mask, wake_cause;
    logic [VEC_W-1:0]      irq_vec;
    logic [PRIO_W-1:0]     irq_prio;
    logic [3:0]            ack_dly;        // stand-in reaction time
    iwc_mode_t             mode;
    int                    failures, cmp_count, cyc;
    iwc_ctrl dut (
        .i_clk(clk), .i_resetn(resetn), .i_ce(ce), .i_irq(irq), .i_irq_en(irq_en), .i_prio(prio),
        .i_core_ack(core_ack), .i_core_exit(core_exit), .i_slp_irq(slp_irq), .i_slp_evt(slp_evt),
        .i_event(evt),
        .i_stop_cfg(stop_cfg), .i_vlp(vlp), .i_clk_stable(clk_stable), .i_reset_src(reset_src),
        .i_pin_int(pin_int), .i_pin_int_en(pin_en), .i_clkd_evt(clkd_evt), .i_clkd_sel(clkd_sel),
        .i_conv_wake_en(conv_en), .i_free_evt(free_evt), .i_gen_evt(gen_evt), .i_gen_slow(gen_slow),
        .i_wake_mask(wake_mask), .o_irq_req(irq_req), .o_irq_vec(irq_vec), .o_irq_prio(irq_prio),
        .o_core_sleep(core_sleep), .o_sys_clk_run(sys_clk_run), .o_mode(mode), .o_wake(wake),
        .o_wake_cause(wake_cause));
    iwc_core_model #(.SETTLE(3)) core (
        .i_clk(clk), .i_resetn(resetn), .i_ack_dly(ack_dly), .i_irq_req(irq_req),
        .i_sys_clk_run(sys_clk_run), .o_core_ack(core_ack), .o_clk_stable(clk_stable));
    // inputs change 1 ns after the rising edge
    task automatic tick(input int n = 1);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic close_out();
        if (failures == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // one-cycle source pulse; pending holds it
    task automatic fire(input int v, input logic [1:0] p);
        prio[2*v+:2] = p;
        irq[v] = 1'b1;
        tick();
        irq[v] = 1'b0;
    endtask
    // wait for the request, judge it, let the stand-in take it
    task automatic take(input int v, input logic [1:0] p);
        int n;
        n = 0;
        while (irq_req !== 1'b1 && n < 20) begin
            tick();
            n++;
        end
        irq = '0;                          // level sources drop once served
        chk("latency", 1, n < LAT_MAX_CYC);
        chk("vector", v, irq_vec);
        chk("level", p, irq_prio);
        while (irq_req === 1'b1 && n < 40) begin
            tick();
            n++;
        end
    endtask
    task automatic done();
        core_exit = 1'b1;
        tick();
        core_exit = 1'b0;
        tick();
    endtask
    task automatic sleep(input logic [1:0] cfg, input logic v, input logic e, input iwc_mode_t m);
        stop_cfg = cfg;
        vlp = v;
        slp_irq = !e;
        slp_evt = e;
        tick();
        {slp_irq, slp_evt} = 2'b00;
        tick();
        chk("mode", m, mode);
        chk("sleeping", 1, core_sleep);
        chk("clk_run", m < IWC_STOP, sys_clk_run);
    endtask
    // wake expected or not; an unwoken stop is ended by a reset-type source
    task automatic probe(input logic hit, input int b);
        int n;
        n = 0;
        while (wake !== 1'b1 && n < 4) begin
            tick();
            n++;
        end
        chk("woke", hit, wake === 1'b1);
        if (hit) chk("cause", 32'h1 << b, wake_cause);
        {reset_src, pin_int, clkd_evt, free_evt, gen_evt} = '0;
        if (!hit) begin
            reset_src[3] = 1'b1;
            tick(2);
            reset_src = '0;
        end
        while (mode !== IWC_RUN && n < 30) begin
            tick();
            n++;
        end
        chk("resumed", 1, mode === IWC_RUN);
    endtask
    task automatic t_nest();
        fire(5, 2'd2);
        take(5, 2'd2);
        fire(9, 2'd0);
        take(9, 2'd0);
        fire(3, 2'd1);
        tick(6);
        chk("held_low", 0, irq_req);
        done();
        take(3, 2'd1);
        done();
        done();
        prio[8+:2] = 2'd1;                 // vectors 4 and 7 tie
        prio[14+:2] = 2'd1;
        irq = 32'h0000_0090;
        tick();
        take(4, 2'd1);
        tick(4);
        chk("held_equal", 0, irq_req);
        done();
        take(7, 2'd1);
        done();
    endtask
    task automatic t_wait();
        ack_dly = 4'h4;                    // slow core while sweeping levels
        for (int l = 0; l < NUM_LVL; l++) begin
            fire(8*l + 1, l[1:0]);
            take(8*l + 1, l[1:0]);
            done();
        end
        ack_dly = 4'h0;
        for (int k = 0; k < 2; k++) begin
            // code 3 has no stop meaning and falls back to wait
            sleep(k ? CFG_WAIT : 2'h3, k[0], 1'b0, k ? IWC_LPWAIT : IWC_WAIT);
            fire(12, 2'd3);
            take(12, 2'd3);
            chk("awake", 0, core_sleep);
            done();
        end
        sleep(CFG_WAIT, 1'b0, 1'b1, IWC_WAIT);
        evt = 1'b1;
        tick();
        evt = 1'b0;
        tick();
        chk("event_wake", IWC_RUN, mode);
    endtask
    task automatic t_stop();
        iwc_mode_t m[3] = '{IWC_STOP, IWC_LPSTOP, IWC_PSTOP};
        for (int k = 0; k < 3; k++) begin
            sleep(k == 2 ? CFG_PSTOP : CFG_STOP, k == 1, 1'b0, m[k]);
            prio[4+:2] = 2'd1;
            irq[2] = 1'b1;
            tick(3);
            chk("frozen", 0, irq_req);
            pin_int[3] = 1'b1;
            probe(1'b1, WS_PIN);
            take(2, 2'd1);
            done();
        end
        for (int k = 0; k < 2; k++) begin
            sleep(CFG_STOP, 1'b0, 1'b0, IWC_STOP);
            pin_en = k ? 8'hff : 8'h00;
            wake_mask[WS_PIN] = !k;
            pin_int = 8'h01;
            probe(1'b0, 0);
        end
        {pin_en, wake_mask} = '1;
        for (int i = 0; i < NUM_RST; i++) begin
            sleep(CFG_STOP, 1'b0, 1'b0, IWC_STOP);
            wake_mask = '0;                // reset group ignores the mask
            reset_src[i] = 1'b1;
            probe(1'b1, WS_RESET);
            wake_mask = '1;
        end
    endtask
    task automatic t_srcs();
        for (int c = 0; c < 4*NUM_CLKD + 1; c++) begin
            sleep(CFG_STOP, c[0], 1'b0, c[0] ? IWC_LPSTOP : IWC_STOP);
            conv_en = c < 4*NUM_CLKD;
            // last pass: converter on slow osc but not opted in
            clkd_sel = 12'h555;
            clkd_evt = 6'h20;
            if (c < 4*NUM_CLKD) begin
                clkd_sel = '1;
                clkd_sel[2*(c/4)+:2] = c[1:0];
                clkd_evt = 6'h01 << (c/4);
            end
            probe(c[1] ^ c[0] && c < 4*NUM_CLKD, WS_CLKD0 + c/4);
        end
        for (int s = 0; s < 3; s++) begin
            sleep(CFG_STOP, s == 1, 1'b0, s == 1 ? IWC_LPSTOP : IWC_STOP);
            gen_slow = s != 2;
            gen_evt = 1'b1;
            probe(s == 0, WS_GEN);
        end
        for (int k = 0; k < 2*NUM_FREE; k++) begin
            sleep(CFG_STOP, 1'b1, 1'b0, IWC_LPSTOP);
            wake_mask[WS_FREE0 + k/2] = k[0]; // even pass masked
            free_evt[k/2] = 1'b1;
            probe(k[0], WS_FREE0 + k/2);
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            failures++;
            close_out();
        end
    end
    initial begin
        {resetn, irq, core_exit, slp_irq, slp_evt, evt, vlp, stop_cfg, reset_src, pin_int} = '0;
        {clkd_evt, conv_en, gen_evt, gen_slow, free_evt, ack_dly} = '0;
        {ce, irq_en, prio, pin_en, wake_mask, clkd_sel} = '1;
        failures = 0;
        cmp_count = 0;
        cyc = 0;
        tick(12);
        resetn = 1'b1;
        t_nest();
        t_wait();
        t_stop();
        t_srcs();
        close_out();
    end
endmodule // iwc_ctrl_bench
